// File: common/tcpc_defines.svh
`ifndef TCPC_DEFINES_SVH
`define TCPC_DEFINES_SVH

// Count loaded at every end of period
`define TCPC_RELOAD_VALUE 32'h00000001
// Count held after system reset
`define TCPC_RESET_COUNT 32'h00000000
// Largest prescale shift, a ratio of 4096
`define TCPC_PRES_MAX_SHIFT 4'hC
// Mode select codes
`define TCPC_CODE_COUNTER 3'h2
`define TCPC_CODE_PWM 3'h3
`define TCPC_CODE_CAPTURE 3'h4

`endif

// File: common/tcpc_pkg.sv
`include "tcpc_defines.svh"

package tcpc_pkg;

  // Mode select field encodings
  typedef enum logic [2:0] {
    TCPC_MODE_COUNTER = `TCPC_CODE_COUNTER,
    TCPC_MODE_PWM = `TCPC_CODE_PWM,
    TCPC_MODE_CAPTURE = `TCPC_CODE_CAPTURE
  } tcpc_mode_t;

  // Control settings held by software
  typedef struct packed {
    logic timerEnable;
    logic [2:0] modeSelect;
    logic [3:0] prescaleSelect;
    logic pinPolarity;
  } tcpc_cfg_t;

endpackage : tcpc_pkg

// File: core/tcpc_timer.sv
`include "tcpc_defines.svh"

// Notes on behaviour
// RULE1: Counter mode advances the count once per qualifying pin transition.
// RULE2: Counter mode counts rising or falling edges only, picked by polarity.
// RULE3: Counter mode ignores the prescaler; pin edges sampled on clk only.
// RULE4: The pin source keeps its edge rate at most a quarter of clk.
// RULE5: Counter mode reloads one and flags on the clk edge after match.
// RULE6: A software count affects only the first period; later ones start at 1.
// RULE7: PWM mode toggles the pin when count equals match value, keeps counting.
// RULE8: PWM mode at compare reloads one, toggles, flags and resumes counting.
// RULE9: Polarity zero: PWM starts low, high at match, low at compare.
// RULE10: Polarity one: PWM starts high, low at match, high at compare.
// RULE11: Software sets compare strictly above the match value in PWM mode.
// RULE12: Later PWM periods last compare value prescaled timer ticks.
// RULE13: PWM and capture count on the tick of clk divided by prescaler.
// RULE14: Capture copies count to match value, reloads one and flags.
// RULE15: Capture without edge reloads one at compare and flags, no copy.
// RULE16: Capture acts on the timer tick after the pin edge is seen.
// RULE17: Software disables the timer before changing any setting.
// RULE18: The flag clear strobe clears the period flag; every period end sets it.
// RULE19: Prescaler divides clk by 1 up to 4096, chosen by prescale field.
// RULE20: Reset leaves the count at zero, first period one tick longer.
// RULE21: Pin events are latched until the next timer tick uses them; only capture mode latches, counter mode counts edges on clk.
// RULE22: The pin passes two flip-flops, edges from current versus previous.
module tcpc_timer #(
  parameter int WIDTH = 32,
  parameter int PRES_W = 12
) (
  input wire logic clk, // 10 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire tcpc_pkg::tcpc_cfg_t cfg, // Control settings
  input wire logic [WIDTH-1:0] compareValue, // Period end value
  input wire logic countWrite, // Count write strobe
  input wire logic [WIDTH-1:0] countWrData, // Count write data
  input wire logic matchWrite, // Match value write strobe
  input wire logic [WIDTH-1:0] matchWrData, // Match value write data
  input wire logic flagClear, // Period flag clear strobe
  input wire logic timerPinIn, // Timer pin level, asynchronous
  output logic [WIDTH-1:0] countValue, // Current count
  output logic [WIDTH-1:0] matchCaptureValue, // Match or captured count
  output logic periodEventFlag, // Sticky period end flag
  output logic timerPinOut, // Timer pin drive level
  output logic timerPinOe // Timer pin drive enable
);
  import tcpc_pkg::*;

  // ****************************************************
  // Pin synchroniser and edge detect
  // ****************************************************
  logic pinSync1_q, pinSync2_q, pinPrev_q;
  logic selEdge;

  // Two stages, then a history stage for edges
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end
    else
    begin
      pinSync1_q <= timerPinIn; // RULE22
      pinSync2_q <= pinSync1_q; // RULE22
      pinPrev_q <= pinSync2_q; // RULE22
    end
  end

  // Rising edge for polarity zero, falling for one
  assign selEdge = cfg.pinPolarity ? (pinPrev_q && !pinSync2_q)
                                   : (!pinPrev_q && pinSync2_q); // RULE2

  // ****************************************************
  // Prescaler
  // ****************************************************
  logic [PRES_W-1:0] presCnt_q, presCnt_d;
  logic [PRES_W-1:0] presLimit;
  logic [3:0] presShift;
  logic presTick;

  // Ratio is a power of two, clamped to 4096
  always_comb
  begin
    presShift = (cfg.prescaleSelect > `TCPC_PRES_MAX_SHIFT)
              ? `TCPC_PRES_MAX_SHIFT : cfg.prescaleSelect; // RULE19
    presLimit = ~({PRES_W{1'b1}} << presShift); // RULE19
    presTick = cfg.timerEnable && (presCnt_q == presLimit); // RULE13
    presCnt_d = presCnt_q + 1'b1;
    if (!cfg.timerEnable || presTick)
    begin
      presCnt_d = '0;
    end
  end

  // Prescale counter register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      presCnt_q <= '0;
    end
    else
    begin
      presCnt_q <= presCnt_d;
    end
  end

  // ****************************************************
  // Counter, match, flag and pin output
  // ****************************************************
  logic [WIDTH-1:0] count_q, count_d;
  logic [WIDTH-1:0] match_q, match_d;
  logic flag_q, flag_d;
  logic pinOut_q, pinOut_d;
  logic edgePend_q, edgePend_d;
  logic running, atCompare, periodEnd;

  always_comb
  begin
    count_d = count_q;
    match_d = match_q;
    pinOut_d = pinOut_q;
    edgePend_d = edgePend_q;
    periodEnd = 1'b0;
    running = cfg.timerEnable;
    atCompare = (count_q == compareValue);
    if (!running)
    begin
      pinOut_d = cfg.pinPolarity; // RULE9 RULE10
      edgePend_d = 1'b0;
    end
    else
    begin
      unique case (cfg.modeSelect)
        TCPC_MODE_COUNTER:
        begin
          if (atCompare)
          begin
            count_d = `TCPC_RELOAD_VALUE; // RULE5 RULE6
            periodEnd = 1'b1; // RULE5
          end
          else if (selEdge)
          begin
            count_d = count_q + 1'b1; // RULE1 RULE3
          end
        end
        TCPC_MODE_PWM:
        begin
          if (presTick)
          begin
            if (atCompare)
            begin
              count_d = `TCPC_RELOAD_VALUE; // RULE8 RULE12
              pinOut_d = !pinOut_q; // RULE8
              periodEnd = 1'b1; // RULE8
            end
            else
            begin
              count_d = count_q + 1'b1; // RULE13
              if (count_q == match_q)
              begin
                pinOut_d = !pinOut_q; // RULE7
              end
            end
          end
        end
        TCPC_MODE_CAPTURE:
        begin
          if (presTick)
          begin
            edgePend_d = 1'b0;
            if (edgePend_q)
            begin
              match_d = count_q; // RULE14 RULE16
              count_d = `TCPC_RELOAD_VALUE; // RULE14
              periodEnd = 1'b1; // RULE14
            end
            else if (atCompare)
            begin
              count_d = `TCPC_RELOAD_VALUE; // RULE15
              periodEnd = 1'b1; // RULE15
            end
            else
            begin
              count_d = count_q + 1'b1; // RULE13
            end
          end
          // Edge seen on a tick cycle waits for the next tick
          if (selEdge)
          begin
            edgePend_d = 1'b1; // RULE21
          end
        end
        default:
        begin
          count_d = count_q;
        end
      endcase
    end
    if (countWrite)
    begin
      count_d = countWrData; // RULE6
    end
    if (matchWrite)
    begin
      match_d = matchWrData;
    end
    // Set wins over a clear in the same cycle
    flag_d = periodEnd || (flag_q && !flagClear); // RULE18
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_q <= `TCPC_RESET_COUNT; // RULE20
      match_q <= '0;
      flag_q <= 1'b0;
      pinOut_q <= 1'b0;
      edgePend_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      match_q <= match_d;
      flag_q <= flag_d;
      pinOut_q <= pinOut_d;
      edgePend_q <= edgePend_d;
    end
  end

  assign countValue = count_q;
  assign matchCaptureValue = match_q;
  assign periodEventFlag = flag_q;
  assign timerPinOut = pinOut_q;
  assign timerPinOe = (cfg.modeSelect == TCPC_MODE_PWM);

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic quiet;
  assign quiet = !countWrite && !matchWrite && cfg.timerEnable;

  sequence s_capEvent;
    quiet && cfg.modeSelect == TCPC_MODE_CAPTURE && presTick && edgePend_q;
  endsequence

  sequence s_capDone;
    count_q == `TCPC_RELOAD_VALUE && flag_q;
  endsequence

  a_count_reload: assert property ( // RULE5
    quiet && cfg.modeSelect == TCPC_MODE_COUNTER && atCompare
    |=> count_q == `TCPC_RELOAD_VALUE && flag_q)
    else $error("counter mode reload missing");
  a_counter_edge: assert property ( // RULE1
    quiet && cfg.modeSelect == TCPC_MODE_COUNTER && selEdge && !atCompare
    |=> count_q == $past(count_q) + 1'b1)
    else $error("counter mode edge not counted");
  a_counter_still: assert property ( // RULE3
    quiet && cfg.modeSelect == TCPC_MODE_COUNTER && !selEdge && !atCompare
    |=> $stable(count_q))
    else $error("counter moved without edge");
  a_pwm_match: assert property ( // RULE7
    quiet && cfg.modeSelect == TCPC_MODE_PWM && presTick && !atCompare
    && count_q == match_q |=> timerPinOut != $past(timerPinOut))
    else $error("pwm match toggle missing");
  a_pwm_period: assert property ( // RULE8
    quiet && cfg.modeSelect == TCPC_MODE_PWM && presTick && atCompare
    |=> count_q == `TCPC_RELOAD_VALUE && timerPinOut != $past(timerPinOut))
    else $error("pwm period end wrong");
  a_idle_level: assert property ( // RULE9
    !cfg.timerEnable ##1 !cfg.timerEnable
    |-> timerPinOut == $past(cfg.pinPolarity))
    else $error("idle pin level wrong");
  a_capture_copy: assert property ( // RULE14
    s_capEvent |=> s_capDone ##0 match_q == $past(count_q))
    else $error("capture copy wrong");
  a_flag_hold: assert property ( // RULE18
    flag_q && !flagClear |=> flag_q)
    else $error("period flag lost");
  a_flag_clear: assert property ( // RULE18
    flag_q && flagClear && !periodEnd |=> !flag_q)
    else $error("period flag not cleared");

endmodule : tcpc_timer

// File: sim/tcpc_pin_source.sv
// ****************************************
// Far-side pulse source on the timer pin
// ****************************************
module tcpc_pin_source (
  input wire logic clk, // Pacing clock
  input wire logic start, // Burst request
  input wire logic [3:0] pulses, // Pulses per burst
  input wire logic [7:0] gap, // Clocks per half pulse
  input wire logic idleHigh, // Resting pin level
  output logic pinLevel, // Pin drive level
  output logic busy // Burst in progress
);
  timeunit 1ns;
  timeprecision 1ns;
  logic active;
  int half;

  // Active half is the inverse of the resting level
  assign pinLevel = active ? !idleHigh : idleHigh;

  // Burst player, rising to rising exactly two halves apart
  initial
  begin
    active = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (start)
      begin
        busy = 1'b1;
        half = (gap < 8'h04) ? 4 : int'(gap);
        repeat (pulses)
        begin
          @(negedge clk);
          active = 1'b1;
          repeat (half) @(negedge clk);
          active = 1'b0;
          repeat (half - 1) @(negedge clk);
        end
        busy = 1'b0;
      end
    end
  end
endmodule : tcpc_pin_source

// File: sim/tcpc_timer_bench.sv
module tcpc_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcpc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  tcpc_cfg_t cfg = 9'h000;
  logic [31:0] cmpV = 32'h0, cntD = 32'h0, mD = 32'h0;
  logic cntWr = 1'b0, mWr = 1'b0, fClr = 1'b0;
  logic start = 1'b0, idleHigh = 1'b0, pinSrc, pinWire, busy;
  logic [3:0] pulses = 4'h1;
  logic [7:0] gap = 8'h04;
  logic [31:0] cnt, mcv;
  logic flag, pOut, pOe;
  int numErrors = 0;
  int samplesChecked = 0;
  int hi, lo;

  // Clock of 100 ns period
  always #50 clk = !clk;
  // Pin level: timer drives in PWM mode, else the source
  assign pinWire = pOe ? pOut : pinSrc;

  tcpc_timer dut_u (
    .clk(clk), .reset(reset), .cfg(cfg), .compareValue(cmpV),
    .countWrite(cntWr), .countWrData(cntD), .matchWrite(mWr),
    .matchWrData(mD), .flagClear(fClr), .timerPinIn(pinWire),
    .countValue(cnt), .matchCaptureValue(mcv), .periodEventFlag(flag),
    .timerPinOut(pOut), .timerPinOe(pOe)
  );

  tcpc_pin_source src_u (
    .clk(clk), .start(start), .pulses(pulses), .gap(gap),
    .idleHigh(idleHigh), .pinLevel(pinSrc), .busy(busy)
  );

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task testDone;
    $display("Checks %0d, errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : testDone

  task setup(input tcpc_mode_t md, input logic [3:0] p, input logic pl,
    input logic [31:0] c, input logic [31:0] n, input logic [31:0] m);
    @(negedge clk);
    cfg.timerEnable = 1'b0;
    idleHigh = pl;
    repeat (4) @(negedge clk);
    cfg = '{1'b0, md, p, pl};
    cmpV = c;
    cntD = n;
    mD = m;
    {cntWr, mWr, fClr} = 3'h7;
    @(negedge clk);
    {cntWr, mWr, fClr} = 3'h0;
    cfg.timerEnable = 1'b1;
  endtask : setup

  task burst(input logic [3:0] n, input logic [7:0] g);
    int k;
    pulses = n;
    gap = g;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 5000)
    begin
      @(negedge clk);
      k++;
    end
    repeat (6) @(negedge clk);
  endtask : burst

  task waitPin(input logic v, output int n);
    n = 0;
    while (pOut !== v && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : waitPin

  task pwm(input logic pl, input logic [3:0] p, input logic [31:0] c,
    input logic [31:0] m);
    setup(TCPC_MODE_PWM, p, pl, c, 32'h1, m);
    check(32'(pOut), 32'(pl));
    check(32'(pOe), 32'h1);
    waitPin(!pl, hi);
    waitPin(pl, hi);
    waitPin(!pl, lo);
    check(32'(hi), (c - m) << p);
    check(32'(lo), m << p);
    check(32'(hi + lo), c << p);
    check(32'(flag), 32'h1);
  endtask : pwm

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check(cnt, 32'h0);
    check(mcv, 32'h0);
    check(32'(flag), 32'h0);
    // Counter mode: written count shortens the first period
    setup(TCPC_MODE_COUNTER, 4'hF, 1'b0, 32'h3, 32'h2, 32'h0);
    burst(4'h1, 8'h06);
    check(cnt, 32'h1);
    check(32'(flag), 32'h1);
    fClr = 1'b1;
    @(negedge clk);
    fClr = 1'b0;
    check(32'(flag), 32'h0);
    burst(4'h1, 8'h04);
    check(cnt, 32'h2);
    // Polarity one counts falling edges only
    setup(TCPC_MODE_COUNTER, 4'h0, 1'b1, 32'h9, 32'h1, 32'h0);
    burst(4'h2, 8'h08);
    check(cnt, 32'h3);
    check(32'(flag), 32'h0);
    // PWM at ratios 1, 2 and 4
    pwm(1'b0, 4'h0, 32'h6, 32'h2);
    pwm(1'b1, 4'h1, 32'h5, 32'h3);
    pwm(1'b0, 4'h2, 32'h4, 32'h1);
    // Capture of edges 20 clocks apart at ratio 2
    setup(TCPC_MODE_CAPTURE, 4'h1, 1'b0, 32'hC8, 32'h1, 32'h0);
    burst(4'h3, 8'h0A);
    check(mcv, 32'hA);
    check(32'(flag), 32'h1);
    // No edge: compare ends the period, match kept
    setup(TCPC_MODE_CAPTURE, 4'h0, 1'b0, 32'h14, 32'h1, 32'h55);
    repeat (25) @(negedge clk);
    check(mcv, 32'h55);
    check(32'(flag), 32'h1);
    testDone;
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    numErrors++;
    testDone;
  end
endmodule : tcpc_timer_bench
